// File: clock_control_params.svh
// Offsets, field positions, reset values and counts of the mode and clock controller.
// Assumes a 32-bit AHB-Lite register window with byte addresses below 0x10.
//
// Overview of operation
// - Slow oscillator also feeds watchdog and time base logic.
// - System clock chosen by full-speed bit plus three-bit divider field.
// - Sub clock comes from slow RC or slow crystal, fixed by option.
// - Fast clock divided by 2 down to 64 offered as system clock.
// - Switching to the slow source stops the fast oscillator.
// - Sub clock may stand in as system clock right after wake-up.
// - Time base clock is sub clock or system clock divided by four.
// - Sub clock offered to watchdog, timer modules and serial interface.
// - Six modes; CPU runs only in normal and slow, and in the sub-clocked wake-up after a halt.
// - Per-mode system and sub clock state follows the mode table.
// - Normal mode runs from fast crystal divided by 1 to 64.
// - Slow mode runs from a slow oscillator, fast clock off.
// - Halt with halt_idle_select low enters a sleep mode.
// - Deep sleep stops CPU and sub clock, disables watchdog.
// - Deep sleep is not entered while voltage_detect_enable is 1.
// - Light sleep keeps sub clock if voltage detect or watchdog enabled.
// - Halt with idle select high, keep-on low enters idle_clocks_stopped.
// - Idle clocks stopped halts system oscillator; sub-clocked peripherals run.
// - Both idle modes keep sub clock on, whether or not watchdog is enabled.
// - Halt with idle select and keep-on high enters idle_clocks_running.
// - Idle clocks running gates CPU, keeps selected oscillator for peripherals.
// - Divider codes 000/001 sub clock; 010..111 fast over 64..2.
// - Full-speed bit 1 gives undivided fast clock; 0 uses divider field.
`ifndef CLOCK_CONTROL_PARAMS_SVH
`define CLOCK_CONTROL_PARAMS_SVH

`define ADDR_CLOCK_MODE 8'h00
`define ADDR_CONTROL_ZERO 8'h04
`define ADDR_POWER_CONTROL 8'h08
`define ADDR_POWER_STATUS 8'h0C

`define CM_CKS_LSB 5
`define CM_FAST_WAKE_BIT 4
`define CM_IDLE_SEL_BIT 1
`define CM_FULL_SPEED_BIT 0
`define CZ_KEEP_ON_BIT 7
`define PC_VDE_BIT 0
`define PC_WDT_EN_BIT 1
`define PC_TB_SRC_BIT 2

`define CKS_RESET 3'h6
`define FAST_WAKE_RESET 1'h0
`define IDLE_SEL_RESET 1'h1
`define FULL_SPEED_RESET 1'h0
`define KEEP_ON_RESET 1'h0
`define VDE_RESET 1'h0
`define WDT_EN_RESET 1'h1
`define TB_SRC_RESET 1'h0

`define CKS_FIRST_FAST 3'h2
`define DIV_SHIFT_BASE 3'h0
`define TB_SYS_DIV 2'h3
`define FAST_SETTLE_CYCLES 1024

`endif

// File: clock_control_pkg.sv
// Types of the mode and clock controller.
// Assumes the constants header is included by whoever needs numbers.
package clock_control_pkg;

    typedef enum logic [2:0] {
        ST_ACTIVE, ST_DEEP, ST_LIGHT, ST_IDLE_STOP, ST_IDLE_RUN, ST_WAKE_SUB, ST_WAKE_FAST
    } pwr_state_t;

    typedef enum logic [1:0] {SRC_SUB, SRC_DIV, SRC_FULL} src_kind_t;

    typedef struct packed {
        src_kind_t kind;
        logic [2:0] shift;
    } src_sel_t;

    typedef struct packed {
        logic sys_tick;
        logic cpu_tick;
        logic sub_tick;
        logic wdt_tick;
        logic timebase_tick;
    } clk_taps_t;

endpackage : clock_control_pkg

// File: operating_mode_clock_control.sv
// Power mode sequencer and system clock selector, as an AHB-Lite slave.
// Assumes halt_exec and wake_event come from logic on this clock; slow oscillator
// pins are asynchronous. Clock outputs are one-cycle ticks on the fast clock.
`timescale 1ns/10ps
`default_nettype none
`include "clock_control_params.svh"

module operating_mode_clock_control
    import clock_control_pkg::*;
#(
    parameter int SETTLE_CYCLES = `FAST_SETTLE_CYCLES
) (
    input wire logic clock,
    input wire logic reset,
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic hresp,
    output logic [31:0] hrdata,
    input wire logic slow_rc_osc,
    input wire logic slow_crystal_osc,
    input wire logic sub_source_option,
    input wire logic halt_exec,
    input wire logic wake_event,
    output clk_taps_t taps,
    output logic fast_osc_enable,
    output logic sub_osc_enable,
    output logic wdt_run,
    output logic slow_mode,
    output pwr_state_t pwr_state
);

    // ************************************************************
    // Functions
    // ************************************************************
    function automatic src_sel_t decode_sel(input logic full, input logic [2:0] cks);
        src_sel_t s;
        s.kind = SRC_SUB;
        s.shift = `DIV_SHIFT_BASE;
        if (full) begin
            s.kind = SRC_FULL;
        end else if (cks >= `CKS_FIRST_FAST) begin
            s.kind = SRC_DIV;
            s.shift = 3'h0 - cks;
        end
        return s;
    endfunction : decode_sel

    function automatic logic [5:0] div_mask(input logic [2:0] shift);
        logic [5:0] m;
        m = 6'h00;
        for (int i = 0; i < 6; i++) begin
            if (i < int'(shift)) begin
                m[i] = 1'b1;
            end
        end
        return m;
    endfunction : div_mask

    // ************************************************************
    // Register bus
    // ************************************************************
    logic [2:0] cks_q;
    logic fast_wake_q;
    logic idle_sel_q;
    logic full_speed_q;
    logic keep_on_q;
    logic vde_q;
    logic wdt_en_q;
    logic tb_src_q;
    logic wr_pend_q;
    logic [7:0] wr_addr_q;
    logic [31:0] rd_word;
    logic addr_take;
    pwr_state_t state_q;
    src_sel_t cur_q;
    logic fast_on_q;
    logic sub_on_q;

    assign addr_take = hsel && htrans[1] && hready;

    always_ff @(posedge clock) begin
        if (reset) begin
            wr_pend_q <= 1'b0;
            wr_addr_q <= 8'h00;
        end else begin
            wr_pend_q <= addr_take && hwrite;
            if (addr_take) begin
                wr_addr_q <= haddr[7:0];
            end
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            cks_q <= `CKS_RESET;
            fast_wake_q <= `FAST_WAKE_RESET;
            idle_sel_q <= `IDLE_SEL_RESET;
            full_speed_q <= `FULL_SPEED_RESET;
            keep_on_q <= `KEEP_ON_RESET;
            vde_q <= `VDE_RESET;
            wdt_en_q <= `WDT_EN_RESET;
            tb_src_q <= `TB_SRC_RESET;
        end else if (wr_pend_q) begin
            case (wr_addr_q)
                `ADDR_CLOCK_MODE: begin
                    cks_q <= hwdata[`CM_CKS_LSB +: 3];
                    fast_wake_q <= hwdata[`CM_FAST_WAKE_BIT];
                    idle_sel_q <= hwdata[`CM_IDLE_SEL_BIT];
                    full_speed_q <= hwdata[`CM_FULL_SPEED_BIT];
                end
                `ADDR_CONTROL_ZERO: begin
                    keep_on_q <= hwdata[`CZ_KEEP_ON_BIT];
                end
                `ADDR_POWER_CONTROL: begin
                    vde_q <= hwdata[`PC_VDE_BIT];
                    wdt_en_q <= hwdata[`PC_WDT_EN_BIT];
                    tb_src_q <= hwdata[`PC_TB_SRC_BIT];
                end
                default: begin
                end
            endcase
        end
    end

    always_comb begin
        rd_word = 32'h00000000;
        case (haddr[7:0])
            `ADDR_CLOCK_MODE: begin
                rd_word[`CM_CKS_LSB +: 3] = cks_q;
                rd_word[`CM_FAST_WAKE_BIT] = fast_wake_q;
                rd_word[`CM_IDLE_SEL_BIT] = idle_sel_q;
                rd_word[`CM_FULL_SPEED_BIT] = full_speed_q;
            end
            `ADDR_CONTROL_ZERO: begin
                rd_word[`CZ_KEEP_ON_BIT] = keep_on_q;
            end
            `ADDR_POWER_CONTROL: begin
                rd_word[`PC_VDE_BIT] = vde_q;
                rd_word[`PC_WDT_EN_BIT] = wdt_en_q;
                rd_word[`PC_TB_SRC_BIT] = tb_src_q;
            end
            `ADDR_POWER_STATUS: begin
                rd_word[2:0] = state_q;
                rd_word[5:4] = cur_q.kind;
                rd_word[10:8] = cur_q.shift;
                rd_word[12] = fast_on_q;
                rd_word[13] = sub_on_q;
            end
            default: begin
                rd_word = 32'h00000000;
            end
        endcase
    end

    // Read data captured in the address phase, so no wait states are ever needed
    always_ff @(posedge clock) begin
        if (reset) begin
            hrdata <= 32'h00000000;
            hreadyout <= 1'b1;
            hresp <= 1'b0;
        end else begin
            hreadyout <= 1'b1;
            hresp <= 1'b0;
            if (addr_take && !hwrite) begin
                hrdata <= rd_word;
            end
        end
    end

    // ************************************************************
    // Sub clock
    // ************************************************************
    logic rc_s1_q, rc_s2_q, xt_s1_q, xt_s2_q, sub_prev_q;
    logic sub_src_q;
    logic sub_level;
    logic sub_tick_w;

    // Option is a fuse level, stable; taken while reset is held
    always_ff @(posedge clock) begin
        if (reset) begin
            sub_src_q <= sub_source_option;
        end
    end

    // Reset high: a pin already high after reset gives no false rising edge
    always_ff @(posedge clock) begin
        if (reset) begin
            rc_s1_q <= 1'b1;
            rc_s2_q <= 1'b1;
            xt_s1_q <= 1'b1;
            xt_s2_q <= 1'b1;
            sub_prev_q <= 1'b1;
        end else begin
            rc_s1_q <= slow_rc_osc;
            rc_s2_q <= rc_s1_q;
            xt_s1_q <= slow_crystal_osc;
            xt_s2_q <= xt_s1_q;
            sub_prev_q <= sub_level;
        end
    end

    assign sub_level = sub_src_q ? xt_s2_q : rc_s2_q;
    assign sub_tick_w = sub_on_q && sub_level && !sub_prev_q;

    // ************************************************************
    // System clock source selection
    // ************************************************************
    src_sel_t req_w;
    logic [5:0] div_cnt_q;
    logic cur_tick_w;
    logic switch_w;

    assign req_w = decode_sel(full_speed_q, cks_q);

    always_comb begin
        case (cur_q.kind)
            SRC_FULL: cur_tick_w = fast_on_q;
            SRC_DIV: cur_tick_w = fast_on_q && ((div_cnt_q & div_mask(cur_q.shift))
                == div_mask(cur_q.shift));
            default: cur_tick_w = sub_tick_w;
        endcase
    end

    // Changes wait for the end of the running period, or a stopped source
    assign switch_w = (req_w != cur_q) && (cur_tick_w || !fast_on_q
        || (cur_q.kind == SRC_SUB && !sub_on_q));

    always_ff @(posedge clock) begin
        if (reset) begin
            cur_q <= '{kind: SRC_SUB, shift: `DIV_SHIFT_BASE};
            div_cnt_q <= 6'h00;
        end else begin
            if (switch_w) begin
                cur_q <= req_w;
                div_cnt_q <= 6'h00;
            end else if (fast_on_q) begin
                div_cnt_q <= div_cnt_q + 6'h01;
            end
        end
    end

    // ************************************************************
    // Power mode sequencer
    // ************************************************************
    logic [11:0] settle_q;
    logic fast_sel;
    pwr_state_t halt_target;

    assign fast_sel = (cur_q.kind != SRC_SUB);

    always_comb begin
        if (idle_sel_q) begin
            halt_target = keep_on_q ? ST_IDLE_RUN : ST_IDLE_STOP;
        end else begin
            halt_target = vde_q ? ST_LIGHT : ST_DEEP;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            state_q <= ST_ACTIVE;
            settle_q <= 12'h000;
        end else begin
            case (state_q)
                ST_ACTIVE: begin
                    if (halt_exec) begin
                        state_q <= halt_target;
                    end
                end
                ST_IDLE_RUN: begin
                    if (wake_event) begin
                        state_q <= ST_ACTIVE;
                    end
                end
                ST_DEEP, ST_LIGHT, ST_IDLE_STOP: begin
                    if (wake_event) begin
                        settle_q <= 12'(SETTLE_CYCLES - 1);
                        if (!fast_sel) begin
                            state_q <= ST_ACTIVE;
                        end else if (fast_wake_q && sub_on_q) begin
                            state_q <= ST_WAKE_SUB;
                        end else begin
                            state_q <= ST_WAKE_FAST;
                        end
                    end
                end
                ST_WAKE_SUB, ST_WAKE_FAST: begin
                    if (settle_q == 12'h000) begin
                        state_q <= ST_ACTIVE;
                    end else begin
                        settle_q <= settle_q - 12'h001;
                    end
                end
                default: begin
                    state_q <= ST_ACTIVE;
                end
            endcase
        end
    end

    // ************************************************************
    // Oscillator enables
    // ************************************************************
    always_ff @(posedge clock) begin
        if (reset) begin
            fast_on_q <= 1'b1;
            sub_on_q <= 1'b1;
        end else begin
            case (state_q)
                ST_DEEP: begin
                    fast_on_q <= 1'b0;
                    sub_on_q <= 1'b0;
                end
                ST_LIGHT: begin
                    fast_on_q <= 1'b0;
                    sub_on_q <= vde_q || wdt_en_q;
                end
                ST_IDLE_STOP: begin
                    fast_on_q <= 1'b0;
                    sub_on_q <= 1'b1;
                end
                ST_IDLE_RUN: begin
                    fast_on_q <= fast_sel;
                    sub_on_q <= 1'b1;
                end
                default: begin
                    fast_on_q <= fast_sel;
                    sub_on_q <= 1'b1;
                end
            endcase
        end
    end

    // ************************************************************
    // Clock taps
    // ************************************************************
    logic [1:0] tb_cnt_q;
    logic sys_run;
    logic sys_tick_w;
    logic cpu_run_w;

    assign sys_run = (state_q == ST_ACTIVE) || (state_q == ST_IDLE_RUN)
        || (state_q == ST_WAKE_SUB);
    // Wake on sub ticks keeps the CPU going while the fast oscillator settles
    assign sys_tick_w = sys_run && ((state_q == ST_WAKE_SUB) ? sub_tick_w
        : cur_tick_w);
    assign cpu_run_w = (state_q == ST_ACTIVE) || (state_q == ST_WAKE_SUB);

    always_ff @(posedge clock) begin
        if (reset) begin
            tb_cnt_q <= 2'h0;
        end else if (sys_tick_w) begin
            tb_cnt_q <= tb_cnt_q + 2'h1;
        end
    end

    always_ff @(posedge clock) begin
        if (reset) begin
            taps <= '0;
            wdt_run <= 1'b0;
            fast_osc_enable <= 1'b0;
            sub_osc_enable <= 1'b0;
            slow_mode <= 1'b0;
            pwr_state <= ST_ACTIVE;
        end else begin
            taps.sys_tick <= sys_tick_w;
            taps.cpu_tick <= sys_tick_w && cpu_run_w;
            taps.sub_tick <= sub_tick_w;
            taps.wdt_tick <= sub_tick_w && wdt_en_q;
            taps.timebase_tick <= tb_src_q ? (sys_tick_w && tb_cnt_q == `TB_SYS_DIV)
                : sub_tick_w;
            wdt_run <= wdt_en_q && (state_q != ST_DEEP);
            fast_osc_enable <= fast_on_q;
            sub_osc_enable <= sub_on_q;
            slow_mode <= (state_q == ST_ACTIVE) && !fast_sel;
            pwr_state <= state_q;
        end
    end

    // ************************************************************
    // Checks
    // ************************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (reset);

    chk_halt_to_deep: assert property (
        state_q == ST_ACTIVE && halt_exec && !idle_sel_q && !vde_q |=> state_q == ST_DEEP)
        else $error("halt with sleep select did not reach deep sleep");
    chk_deep_blocked: assert property (
        state_q == ST_ACTIVE && halt_exec && !idle_sel_q && vde_q |=> state_q == ST_LIGHT)
        else $error("deep sleep entered with voltage detect on");
    chk_idle_stopped: assert property (
        state_q == ST_ACTIVE && halt_exec && idle_sel_q && !keep_on_q
        |=> state_q == ST_IDLE_STOP)
        else $error("idle with clocks stopped not entered");
    chk_idle_running: assert property (
        state_q == ST_ACTIVE && halt_exec && idle_sel_q && keep_on_q |=> state_q == ST_IDLE_RUN)
        else $error("idle with clocks running not entered");
    chk_deep_sub_off: assert property (
        (state_q == ST_DEEP)[*3] |-> !sub_osc_enable && !wdt_run && !taps.sub_tick)
        else $error("sub clock or watchdog alive in deep sleep");
    chk_light_sub_on: assert property (
        (state_q == ST_LIGHT && (vde_q || wdt_en_q))[*3] |-> sub_osc_enable)
        else $error("sub clock stopped in light sleep");
    chk_cpu_halted: assert property (
        state_q != ST_ACTIVE && state_q != ST_WAKE_SUB |=> !taps.cpu_tick)
        else $error("cpu tick while halted");
    chk_slow_fast_off: assert property (
        (state_q == ST_ACTIVE && cur_q.kind == SRC_SUB)[*3] |-> !fast_osc_enable)
        else $error("fast oscillator running in slow mode");
    chk_full_every: assert property (
        (state_q == ST_ACTIVE && cur_q.kind == SRC_FULL && fast_on_q)[*2] |-> taps.sys_tick)
        else $error("full speed missed a tick");
    chk_half_toggle: assert property (
        (state_q == ST_ACTIVE && fast_on_q && cur_q.kind == SRC_DIV && cur_q.shift == 3'h1)[*3]
        |-> taps.sys_tick != $past(taps.sys_tick))
        else $error("divide by two period wrong");

    cov_deep_sleep: cover property (state_q == ST_ACTIVE ##1 state_q == ST_DEEP
        ##[1:50] state_q == ST_WAKE_FAST);
    cov_fast_wake: cover property (state_q == ST_LIGHT ##1 state_q == ST_WAKE_SUB);
    cov_idle_run: cover property (state_q == ST_IDLE_RUN && taps.sys_tick);

endmodule : operating_mode_clock_control
`default_nettype wire

// File: core_model.sv
// Model of the core and the slow oscillators facing the controller.
// Assumes the bench asks for halt and wake through the two tasks.
`timescale 1ns/10ps
`default_nettype none

module core_model (
    input wire logic clock,
    output logic halt_exec,
    output logic wake_event,
    output logic slow_rc_osc,
    output logic slow_crystal_osc
);
    // ****************************************
    // Slow sources
    // ****************************************
    // Free-running, periods unrelated to the fast clock
    initial begin
        slow_rc_osc = 1'b0;
        forever #83 slow_rc_osc = ~slow_rc_osc;
    end
    initial begin
        slow_crystal_osc = 1'b0;
        forever #127 slow_crystal_osc = ~slow_crystal_osc;
    end
    // ****************************************
    // Halt and wake pulses
    // ****************************************
    initial begin
        halt_exec = 1'b0;
        wake_event = 1'b0;
    end
    // One-cycle pulse, as the core gives on halt completion
    task automatic halt;
        @(posedge clock);
        halt_exec <= 1'b1;
        @(posedge clock);
        halt_exec <= 1'b0;
    endtask : halt
    task automatic wake;
        @(posedge clock);
        wake_event <= 1'b1;
        @(posedge clock);
        wake_event <= 1'b0;
    endtask : wake
endmodule : core_model
`default_nettype wire

// File: testbench.sv
// Self-checking bench for the mode and clock controller.
// Assumes core_model is compiled first; settle count cut to 8 cycles.
`timescale 1ns/10ps
`default_nettype none
`define CHK(a, e) begin check_count++; if ((a) !== (e)) begin n_errors++; \
    $display("ERROR t=%0t got %h exp %h", $time, (a), (e)); end end

module testbench;
    import clock_control_pkg::*;
    logic clock, reset, hsel, hwrite, hreadyout, hresp;
    logic [1:0] htrans;
    logic [31:0] haddr, hwdata, hrdata, rd;
    logic halt_exec, wake_event, slow_rc_osc, slow_crystal_osc;
    logic fast_osc_enable, sub_osc_enable, wdt_run, slow_mode;
    logic sub_option;
    logic [1:0] k;
    logic [5:0] e;
    clk_taps_t taps;
    pwr_state_t pwr_state;
    pwr_state_t want;
    int n_errors = 0;
    int check_count = 0;
    int n;
    // {idle select, keep on, voltage detect, expected state}
    logic [5:0] modes [5] = '{6'h01, 6'h0A, 6'h23, 6'h34, 6'h3C};

    operating_mode_clock_control #(.SETTLE_CYCLES(8)) u_dut (
        .clock(clock), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata),
        .slow_rc_osc(slow_rc_osc), .slow_crystal_osc(slow_crystal_osc),
        .sub_source_option(sub_option), .halt_exec(halt_exec), .wake_event(wake_event),
        .taps(taps), .fast_osc_enable(fast_osc_enable), .sub_osc_enable(sub_osc_enable),
        .wdt_run(wdt_run), .slow_mode(slow_mode), .pwr_state(pwr_state)
    );
    core_model u_core (
        .clock(clock), .halt_exec(halt_exec), .wake_event(wake_event),
        .slow_rc_osc(slow_rc_osc), .slow_crystal_osc(slow_crystal_osc)
    );

    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end
    // ****************************************
    // Tasks
    // ****************************************
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        @(posedge clock);
        hsel <= 1'b1;
        htrans <= 2'h2;
        haddr <= a;
        hwrite <= w;
        do @(posedge clock); while (hreadyout !== 1'b1);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        do @(posedge clock); while (hreadyout !== 1'b1);
        rd = hrdata;
        `CHK(hresp, 1'b0)
    endtask : bus
    // Cycles between two pulses of one tap bit
    task automatic gap(input int b, output int g);
        logic [4:0] tv;
        g = 0;
        do begin @(negedge clock); tv = taps; g++; end while (tv[b] !== 1'b1 && g < 600);
        g = 0;
        do begin @(negedge clock); tv = taps; g++; end while (tv[b] !== 1'b1 && g < 600);
    endtask : gap
    task automatic count(input int b, output int c);
        logic [4:0] tv;
        c = 0;
        repeat (20) begin
            @(negedge clock);
            tv = taps;
            c += (tv[b] === 1'b1);
        end
    endtask : count
    // Source switch waits for a period end, so poll rather than guess
    // Divided sources must also show the new shift, not just the old kind
    task automatic poll(input logic [1:0] kind, input logic [2:0] shift);
        repeat (60) begin
            bus(1'b0, 32'h0C, 32'h0);
            if (rd[5:4] === kind && (kind != 2'h1 || rd[10:8] === shift)) break;
        end
    endtask : poll
    task stop_test;
        if (n_errors == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask : stop_test

    initial begin
        #400000;
        n_errors++;
        stop_test();
    end
    // ****************************************
    // Tests
    // ****************************************
    initial begin
        reset = 1'b1;
        hsel = 1'b0;
        htrans = 2'h0;
        haddr = 32'h0;
        hwrite = 1'b0;
        hwdata = 32'h0;
        sub_option = 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        bus(1'b0, 32'h00, 32'h0);
        `CHK(rd, 32'h000000C2)
        bus(1'b0, 32'h04, 32'h0);
        `CHK(rd, 32'h00000000)
        bus(1'b0, 32'h08, 32'h0);
        `CHK(rd, 32'h00000002)
        bus(1'b1, 32'h10, 32'hFFFFFFFF);
        bus(1'b0, 32'h10, 32'h0);
        `CHK(rd, 32'h00000000)
        poll(2'h1, 3'h2);
        `CHK(rd[13:0], 14'h3210)
        for (int c = 0; c < 9; c++) begin
            k = (c == 8) ? 2'h2 : (c < 2) ? 2'h0 : 2'h1;
            bus(1'b1, 32'h00, (c == 8) ? 32'hC3 : {24'h0, 3'(c), 5'h02});
            poll(k, 3'(8 - c));
            `CHK(rd[5:4], k)
            gap(4, n);
            if (k == 2'h1) begin
                `CHK(rd[10:8], 3'(8 - c))
                `CHK(n, 1 << (8 - c))
                `CHK(fast_osc_enable, 1'b1)
            end
            if (k == 2'h0) begin
                `CHK(n inside {[31:32]}, 1'b1)
                `CHK(fast_osc_enable, 1'b0)
                `CHK(slow_mode, 1'b1)
            end
            if (k == 2'h2) begin
                `CHK(n, 1)
                count(3, n);
                `CHK(n, 20)
            end
        end
        bus(1'b1, 32'h08, 32'h6);
        gap(0, n);
        `CHK(n, 4)
        `CHK(sub_osc_enable, 1'b1)
        for (int m = 0; m < 5; m++) begin
            e = modes[m];
            bus(1'b1, 32'h00, {24'h0, 3'h6, e[3] && !e[5], 2'h0, e[5], 1'b0});
            bus(1'b1, 32'h04, {24'h0, e[4], 7'h0});
            bus(1'b1, 32'h08, {30'h0, 1'b1, e[3]});
            poll(2'h1, 3'h2);
            u_core.halt();
            repeat (4) @(negedge clock);
            `CHK(pwr_state, pwr_state_t'(e[2:0]))
            `CHK(sub_osc_enable, e[2:0] != 3'h1)
            `CHK(wdt_run, e[2:0] != 3'h1)
            `CHK(fast_osc_enable, e[2:0] == 3'h4)
            count(3, n);
            `CHK(n, 0)
            count(4, n);
            `CHK(n, (e[2:0] == 3'h4) ? 5 : 0)
            u_core.wake();
            want = ST_WAKE_FAST;
            if (e[2:0] == 3'h4) want = ST_ACTIVE;
            if (e[2:0] == 3'h2) want = ST_WAKE_SUB;
            repeat (2) @(negedge clock);
            `CHK(pwr_state, want)
            n = 0;
            while (pwr_state !== ST_ACTIVE && n < 200) begin
                @(negedge clock);
                n++;
            end
            `CHK(pwr_state, ST_ACTIVE)
        end
        // Second reset with the RC option
        @(posedge clock);
        sub_option <= 1'b0;
        reset <= 1'b1;
        repeat (2) @(posedge clock);
        reset <= 1'b0;
        bus(1'b0, 32'h00, 32'h0);
        `CHK(rd, 32'h000000C2)
        gap(2, n);
        `CHK(n inside {[20:21]}, 1'b1)
        gap(1, n);
        `CHK(n inside {[20:21]}, 1'b1)
        stop_test();
    end
endmodule : testbench
`default_nettype wire
